// [src/accf_regs.vh]
// Contract
// - Writing run bit one starts counter.
// - Module n match/capture sets flag n.
// - Flags cleared only by software write.
// - Reserved bits read value is undefined.
// - Enabled set event flag requests interrupt.
`ifndef ACCF_REGS_VH
`define ACCF_REGS_VH

// Register offsets on the plain register port.
`define ACCF_OFS_CONTROL    8'h00
`define ACCF_OFS_MODE       8'h01
`define ACCF_OFS_COUNT_LO   8'h02
`define ACCF_OFS_COUNT_HI   8'h03
`define ACCF_OFS_IRQ_STATUS 8'h04
`define ACCF_OFS_IRQ_CLEAR  8'h05
`define ACCF_OFS_IRQ_ENABLE 8'h06

// Field positions of array_counter_control.
`define ACCF_CTL_OVF_BIT    7
`define ACCF_CTL_RUN_BIT    6
`define ACCF_CTL_MOD_HI     4
`define ACCF_CTL_MOD_LO     0

// Field positions of array_counter_mode.
`define ACCF_MODE_SEL_HI    2
`define ACCF_MODE_SEL_LO    1
`define ACCF_MODE_OVF_EN    0

// Field positions of the interrupt status, clear and enable registers.
`define ACCF_IRQ_OVF_BIT    5
`define ACCF_IRQ_MOD_HI     4
`define ACCF_IRQ_MOD_LO     0

// Count pulse select encodings.
`define ACCF_SEL_DIV12      2'h0
`define ACCF_SEL_DIV4       2'h1
`define ACCF_SEL_TIMER0     2'h2
`define ACCF_SEL_EXT        2'h3

// Reset values.
`define ACCF_RST_CONTROL    8'h00
`define ACCF_RST_MODE       8'h00
`define ACCF_RST_COUNT      16'h0000
`define ACCF_RST_ENABLE     5'h00

// Timing counts of the internal count pulse dividers.
`define ACCF_DIV_SLOW       4'hc
`define ACCF_DIV_FAST       4'h4

`endif

// [src/accf_pulse.v]
`include "accf_regs.vh"

module accf_pulse (
  // Clock and reset.
  input  wire       i_clk,
  input  wire       i_rst_n,
  // Source select and sources.
  input  wire [1:0] i_sel,
  input  wire       i_timer0_ovf,
  input  wire       i_ext_count,
  // Selected count pulse.
  output reg        o_pulse
);

  reg [3:0] div_cnt;
  reg [3:0] next_div_cnt;
  reg [2:0] ext_sync;
  reg       ext_level;
  reg       next_pulse;
  wire      slow_tick;
  wire      fast_tick;
  wire      ext_fall;

  // Divider producing one-cycle ticks at osc/12 and osc/4.
  assign slow_tick = (div_cnt == (`ACCF_DIV_SLOW - 4'h1));
  assign fast_tick = (div_cnt[1:0] == 2'h3);

  always @* begin
    if (slow_tick) begin
      next_div_cnt = 4'h0;
    end else begin
      next_div_cnt = div_cnt + 4'h1;
    end
  end

  // External pin: three flops, change accepted when the last two agree.
  assign ext_fall = ext_level & ~ext_sync[1] & ~ext_sync[2];

  always @* begin
    case (i_sel)
      `ACCF_SEL_DIV12:  next_pulse = slow_tick;
      `ACCF_SEL_DIV4:   next_pulse = fast_tick;
      `ACCF_SEL_TIMER0: next_pulse = i_timer0_ovf;
      `ACCF_SEL_EXT:    next_pulse = ext_fall;
      default:          next_pulse = 1'b0;
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      div_cnt   <= 4'h0;
      ext_sync  <= 3'h7;
      ext_level <= 1'b1;
      o_pulse   <= 1'b0;
    end else begin
      div_cnt   <= next_div_cnt;
      ext_sync  <= {ext_sync[1:0], i_ext_count};
      if (ext_sync[1] == ext_sync[2]) begin
        ext_level <= ext_sync[2];
      end
      o_pulse   <= next_pulse;
    end
  end

endmodule

// [src/accf_top.v]
`include "accf_regs.vh"

module accf_top #(
  parameter NUM_MODULES = 5
) (
  // Clock and reset.
  input  wire        i_clk,
  input  wire        i_rst_n,
  // Register port.
  input  wire [7:0]  i_addr,
  input  wire [7:0]  i_wr_data,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [7:0]  o_rd_data,
  // Module events and count sources.
  input  wire [4:0]  i_module_event,
  input  wire        i_timer0_ovf,
  input  wire        i_ext_count,
  // Counter value and interrupt.
  output reg  [15:0] o_count,
  output wire        o_irq
);

  reg        run;
  reg        ovf_flag;
  reg  [4:0] mod_flag;
  reg  [1:0] pulse_sel;
  reg        ovf_irq_en;
  reg  [4:0] mod_irq_en;
  reg        next_run;
  reg        next_ovf_flag;
  reg  [4:0] next_mod_flag;
  reg  [1:0] next_pulse_sel;
  reg        next_ovf_irq_en;
  reg  [4:0] next_mod_irq_en;
  reg [15:0] next_count;
  reg  [7:0] next_rd_data;
  wire       count_pulse;
  wire       ovf_event;
  wire       wr_control;
  wire       wr_mode;
  wire       wr_clear;
  wire       wr_enable;

  // Reset images of the control and mode registers, cut to each field.
  localparam [7:0] RST_CTL  = `ACCF_RST_CONTROL;
  localparam [7:0] RST_MODE = `ACCF_RST_MODE;

  // Decodes a write strobe to one register offset.
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    input       strobe;
    begin
      hit = strobe & (addr == ofs);
    end
  endfunction

  assign wr_control = hit(i_addr, `ACCF_OFS_CONTROL, i_wr);
  assign wr_mode    = hit(i_addr, `ACCF_OFS_MODE, i_wr);
  assign wr_clear   = hit(i_addr, `ACCF_OFS_IRQ_CLEAR, i_wr);
  assign wr_enable  = hit(i_addr, `ACCF_OFS_IRQ_ENABLE, i_wr);

  accf_pulse u_pulse (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .i_sel        (pulse_sel),
    .i_timer0_ovf (i_timer0_ovf),
    .i_ext_count  (i_ext_count),
    .o_pulse      (count_pulse)
  );

  // Counter advances on each selected pulse while running.
  assign ovf_event = run & count_pulse & (o_count == 16'hffff);

  always @* begin
    if (run && count_pulse) begin
      next_count = o_count + 16'h0001;
    end else begin
      next_count = o_count;
    end
  end

  // Run bit changes only by software writes.
  always @* begin
    next_run = run;
    if (wr_control) begin
      next_run = i_wr_data[`ACCF_CTL_RUN_BIT];
    end
  end

  // Flags: software writes the control bits directly, the clear register
  // drops ones, and a hardware event in the same cycle wins.
  always @* begin
    next_ovf_flag = ovf_flag;
    next_mod_flag = mod_flag;
    if (wr_control) begin
      next_ovf_flag = i_wr_data[`ACCF_CTL_OVF_BIT];
      next_mod_flag = i_wr_data[`ACCF_CTL_MOD_HI:`ACCF_CTL_MOD_LO];
    end
    if (wr_clear) begin
      next_ovf_flag = ovf_flag & ~i_wr_data[`ACCF_IRQ_OVF_BIT];
      next_mod_flag = mod_flag & ~i_wr_data[`ACCF_IRQ_MOD_HI:`ACCF_IRQ_MOD_LO];
    end
    next_ovf_flag = next_ovf_flag | ovf_event;
    next_mod_flag = next_mod_flag | i_module_event;
  end

  // Mode and enable registers; the overflow enable is shared by both.
  always @* begin
    next_pulse_sel  = pulse_sel;
    next_ovf_irq_en = ovf_irq_en;
    next_mod_irq_en = mod_irq_en;
    if (wr_mode) begin
      next_pulse_sel  = i_wr_data[`ACCF_MODE_SEL_HI:`ACCF_MODE_SEL_LO];
      next_ovf_irq_en = i_wr_data[`ACCF_MODE_OVF_EN];
    end
    if (wr_enable) begin
      next_ovf_irq_en = i_wr_data[`ACCF_IRQ_OVF_BIT];
      next_mod_irq_en = i_wr_data[`ACCF_IRQ_MOD_HI:`ACCF_IRQ_MOD_LO];
    end
  end

  // Read mux; reserved and unmapped bits read as zero.
  always @* begin
    next_rd_data = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `ACCF_OFS_CONTROL: begin
          next_rd_data[`ACCF_CTL_OVF_BIT] = ovf_flag;
          next_rd_data[`ACCF_CTL_RUN_BIT] = run;
          next_rd_data[`ACCF_CTL_MOD_HI:`ACCF_CTL_MOD_LO] = mod_flag;
        end
        `ACCF_OFS_MODE: begin
          next_rd_data[`ACCF_MODE_SEL_HI:`ACCF_MODE_SEL_LO] = pulse_sel;
          next_rd_data[`ACCF_MODE_OVF_EN] = ovf_irq_en;
        end
        `ACCF_OFS_COUNT_LO: begin
          next_rd_data = o_count[7:0];
        end
        `ACCF_OFS_COUNT_HI: begin
          next_rd_data = o_count[15:8];
        end
        `ACCF_OFS_IRQ_STATUS: begin
          next_rd_data[`ACCF_IRQ_OVF_BIT] = ovf_flag;
          next_rd_data[`ACCF_IRQ_MOD_HI:`ACCF_IRQ_MOD_LO] = mod_flag;
        end
        `ACCF_OFS_IRQ_ENABLE: begin
          next_rd_data[`ACCF_IRQ_OVF_BIT] = ovf_irq_en;
          next_rd_data[`ACCF_IRQ_MOD_HI:`ACCF_IRQ_MOD_LO] = mod_irq_en;
        end
        default: begin
          next_rd_data = 8'h00;
        end
      endcase
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      run        <= RST_CTL[`ACCF_CTL_RUN_BIT];
      ovf_flag   <= RST_CTL[`ACCF_CTL_OVF_BIT];
      mod_flag   <= RST_CTL[`ACCF_CTL_MOD_HI:`ACCF_CTL_MOD_LO];
      pulse_sel  <= RST_MODE[`ACCF_MODE_SEL_HI:`ACCF_MODE_SEL_LO];
      ovf_irq_en <= RST_MODE[`ACCF_MODE_OVF_EN];
      mod_irq_en <= `ACCF_RST_ENABLE;
      o_count    <= `ACCF_RST_COUNT;
      o_rd_data  <= 8'h00;
    end else begin
      run        <= next_run;
      ovf_flag   <= next_ovf_flag;
      mod_flag   <= next_mod_flag;
      pulse_sel  <= next_pulse_sel;
      ovf_irq_en <= next_ovf_irq_en;
      mod_irq_en <= next_mod_irq_en;
      o_count    <= next_count;
      o_rd_data  <= next_rd_data;
    end
  end

  // Interrupt is high while any enabled flag is set.
  assign o_irq = (ovf_flag & ovf_irq_en) | (|(mod_flag & mod_irq_en));

endmodule

// [tb/accf_top_monitor.sv]
module accf_top_monitor #(
  parameter NUM_MODULES = 5
) (
  // Clock, reset and register port.
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [7:0]  i_addr,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rd_data,
  // Events and results.
  input wire logic [4:0]  i_module_event,
  input wire logic [15:0] o_count,
  input wire logic        o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence step_s;
    $past(i_rst_n) && !$stable(o_count);
  endsequence

  sequence flag_rd_s;
    i_rd && (i_addr == 8'h00 || i_addr == 8'h04);
  endsequence

  count_step_a: assert property (step_s |-> o_count == $past(o_count) + 16'h0001)
    else $error("counter jumped");
  flag_read_a: assert property (flag_rd_s |=>
    (o_rd_data[4:0] & $past(i_module_event, 2)) == $past(i_module_event, 2)) else $error("flag not set");
  irq_hold_a: assert property ($fell(o_irq) |-> $past(i_wr) || !$past(i_rst_n)) else $error("irq dropped");
  irq_cause_a: assert property ($rose(o_irq) |->
    $past(i_wr) || $past(i_module_event) != 5'h00 || $past(o_count) == 16'hffff) else $error("irq without cause");
  unmapped_read_a: assert property (i_rd && (i_addr == 8'h05 || i_addr > 8'h06) |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
  rd_idle_a: assert property (!i_rd |=> o_rd_data == 8'h00) else $error("stray read data");
endmodule

bind accf_top accf_top_monitor #(.NUM_MODULES(NUM_MODULES)) u_mon (
  .i_clk, .i_rst_n, .i_addr, .i_wr, .i_rd, .o_rd_data, .i_module_event, .o_count, .o_irq
);

// [tb/testbench.sv]
`include "accf_regs.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; $display("wrong value %0t %h", $time, a); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic        t0 = 1'h0;
  logic        ext = 1'h1;
  logic        irq;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wd = 8'h00;
  logic [7:0]  rdat;
  logic [7:0]  flags = 8'h00;
  logic [4:0]  ev = 5'h00;
  logic [15:0] cnt;
  logic [15:0] exp_cnt = 16'h0000;
  logic [31:0] seed = 32'h2741;
  logic [31:0] r;
  int          mismatches = 0;
  int          checks_done = 0;
  int          inc[4] = '{10, 30, 39, 13};

  accf_top u_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr_data(wd), .i_wr(wr), .i_rd(rd), .o_rd_data(rdat),
    .i_module_event(ev), .i_timer0_ovf(t0), .i_ext_count(ext), .o_count(cnt), .o_irq(irq)
  );

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  task rd_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 `CHK(rdat & m, e & m)
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    forever #20 clk = ~clk;
  end

  initial begin
    #200000;
    mismatches++;
    end_sim;
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    rd_reg(`ACCF_OFS_CONTROL, 8'h00, 8'hdf);
    rd_reg(8'h07, 8'h00, 8'hff);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      wr_reg(`ACCF_OFS_MODE, 8'(k << 1));
      rd_reg(`ACCF_OFS_MODE, 8'(k << 1), 8'h07);
      wr_reg(`ACCF_OFS_CONTROL, 8'h40);
      for (int i = 0; i < 118; i++) begin
        @(posedge clk);
        t0 <= k == 2 && i % 3 == 1;
        ext <= k != 3 || i % 8 > 3 || i > 100;
      end
      wr_reg(`ACCF_OFS_CONTROL, 8'h00);
      exp_cnt += 16'(inc[k]);
      rd_reg(`ACCF_OFS_COUNT_LO, exp_cnt[7:0], 8'hff);
      rd_reg(`ACCF_OFS_COUNT_HI, exp_cnt[15:8], 8'hff);
      `CHK(cnt, exp_cnt)
    end
    $display("count test done");
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      wr_reg(`ACCF_OFS_IRQ_ENABLE, {3'h0, r[12:8]});
      ev <= r[4:0];
      flags |= {3'h0, r[4:0]};
      rd_reg(`ACCF_OFS_IRQ_STATUS, flags, 8'hff);
      @(posedge clk);
      ev <= 5'h00;
      #1 `CHK(irq, |(flags & {3'h0, r[12:8]}))
      wr_reg(`ACCF_OFS_IRQ_CLEAR, {3'h0, r[20:16]});
      flags &= ~{3'h0, r[20:16]};
      rd_reg(`ACCF_OFS_CONTROL, flags, 8'hdf);
    end
    $display("event test done");
    wr_reg(`ACCF_OFS_IRQ_ENABLE, 8'h20);
    wr_reg(`ACCF_OFS_CONTROL, 8'h80);
    #1 `CHK(irq, 1'b1)
    rd_reg(`ACCF_OFS_IRQ_STATUS, 8'h20, 8'hff);
    rd_reg(`ACCF_OFS_MODE, 8'h07, 8'h07);
    wr_reg(`ACCF_OFS_IRQ_CLEAR, 8'h20);
    #1 `CHK(irq, 1'b0)
    rd_reg(`ACCF_OFS_CONTROL, 8'h00, 8'hdf);
    $display("overflow flag test done");
    end_sim;
  end
endmodule
